// >>> rtl/wdw_pkg.sv
// constants and types for the watchdog down-counter
package wdw_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned PRESCALE_PERIOD  = 16384;
  localparam int unsigned PRE_W            = 14;
  localparam int unsigned RESET_PULSE_US   = 30;
  // longest time: rounds down
  localparam int unsigned RESET_PULSE_CYC  = (RESET_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned RESUME_SHORT_CYC = 256;
  localparam int unsigned RESUME_LONG_CYC  = 4096;
  localparam int unsigned TIMER_W          = 13;

  // ==========================================================
  // shortest lead to first decrement, per time base
  localparam int unsigned MIN_BASE = 128;
  localparam int unsigned MIN_STEP = 64;
  localparam logic [7:0]  LSB_TB0  = 8'h3b;
  localparam logic [7:0]  LSB_TB1  = 8'h35;
  localparam logic [7:0]  LSB_TB2  = 8'h23;
  localparam logic [7:0]  LSB_TB3  = 8'h36;

  function automatic logic [PRE_W-1:0] tb_min_lead(input logic [1:0] tb);
    logic [7:0] lsb;
    lsb = LSB_TB0;
    unique case (tb)
      2'h0: lsb = LSB_TB0;
      2'h1: lsb = LSB_TB1;
      2'h2: lsb = LSB_TB2;
      2'h3: lsb = LSB_TB3;
    endcase
    return PRE_W'((32'(lsb) + MIN_BASE) * MIN_STEP);
  endfunction

  // ==========================================================
  // register map
  localparam int unsigned APB_AW    = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CFG  = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;

  localparam int unsigned CTRL_ACT_BIT   = 7;
  localparam int unsigned CTRL_TOP_BIT   = 6;
  localparam logic [6:0]  CTRL_CNT_RESET = 7'h7f;
  localparam logic [6:0]  CNT_EDGE_VALUE = 7'h40;

  localparam int unsigned CFG_RTCIE_BIT = 0;
  localparam int unsigned CFG_TB_LSB    = 1;

  localparam int unsigned STAT_RESET_BIT  = 0;
  localparam int unsigned STAT_FROZEN_BIT = 1;
  localparam int unsigned STAT_ACTIVE_BIT = 2;
  localparam int unsigned STAT_WAIT_BIT   = 3;

  // ==========================================================
  // power-mode sequencer
  typedef enum logic [2:0] {
    WDW_BOOT      = 3'h0,
    WDW_WAIT      = 3'h1,
    WDW_RUN       = 3'h3,
    WDW_HALT_ONE  = 3'h2,
    WDW_HALT_STOP = 3'h6,
    WDW_ACT_HALT  = 3'h7
  } wdw_state_t;

endpackage

// >>> rtl/wdw_timer.sv
// one-shot down-counting delay timer
`timescale 1ns/1ps
module wdw_timer
  import wdw_pkg::*;
#(
  parameter int unsigned W = TIMER_W
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // control
  input  wire logic         start_in,
  input  wire logic [W-1:0] load_in,
  // status
  output logic              busy_out,
  output logic              done_out
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         busy_reg;
  logic         busy_next;
  logic         done_reg;
  logic         done_next;

  // busy stays high for exactly load_in cycles
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start_in) begin
      cnt_next  = load_in;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg <= W'(1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy_out = busy_reg;
  assign done_out = done_reg;

endmodule // wdw_timer

// >>> rtl/wdw_prescaler.sv
// free-running prescaler giving one tick per period
`timescale 1ns/1ps
module wdw_prescaler
  import wdw_pkg::*;
#(
  parameter int unsigned PERIOD = PRESCALE_PERIOD
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // alignment on software write
  input  wire logic             align_in,
  input  wire logic [PRE_W-1:0] min_lead_in,
  // decrement enable
  output logic                  tick_out
);

  logic [PRE_W-1:0] cnt_reg;
  logic [PRE_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;

  always_comb begin
    tick_next = 1'b0;
    if (cnt_reg == '0) begin
      cnt_next  = PRE_W'(PERIOD - 1);
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg - PRE_W'(1);
    end
    // phase is not reset on a write, only pushed out to the shortest lead
    if (align_in && (cnt_next < min_lead_in)) begin
      cnt_next = min_lead_in - PRE_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg  <= PRE_W'(PERIOD - 1);
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule // wdw_prescaler

// >>> rtl/wdw_watchdog.sv
// watchdog down-counter with power-mode handling and apb registers
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - counter decrements once per prescaler period of 16384 clocks
// - six low counter bits loaded by software set 64 timeout steps
// - active and counter 40h to 3Fh starts a low reset pulse
// - counter runs even when disabled; disabled only suppresses the reset
// - disabled after reset; activation is sticky until reset
// - write with activation set and top bit clear forces reset
// - halt while active, rtc interrupt off, halt option on resets
// - plain halt: one more decrement, then frozen and harmless
// - external interrupt ends plain halt; counting resumes after 256/4096 clocks
// - reset ending halt leaves watchdog disabled unless hardware option
// - halt with rtc interrupt enabled enters active-halt, counter frozen
// - active-halt interrupt exit resumes at once; reset exit after delay
// - hardware option keeps watchdog active, activation bit ignored
// - first decrement after write lies between time-base minimum and 16384
// - control register: activation bit 7, counter bits 6:0, reset 7Fh
module wdw_watchdog
  import wdw_pkg::*;
#(
  parameter int unsigned PRESCALE = PRESCALE_PERIOD
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [APB_AW-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // cpu events
  input  wire logic              halt_in,
  input  wire logic              ext_irq_in,
  input  wire logic              osc_irq_in,
  // option byte straps
  input  wire logic              hw_wdg_opt_in,
  input  wire logic              halt_reset_opt_in,
  input  wire logic              long_delay_opt_in,
  // chip reset
  output logic                   reset_req_out,
  output logic                   chip_reset_n_out
);

  // ==========================================================
  // state
  wdw_state_t  state_reg,      state_next;
  logic [6:0]  cnt_reg,        cnt_next;
  logic        act_reg,        act_next;
  logic        rtcie_reg,      rtcie_next;
  logic [1:0]  tb_reg,         tb_next;
  logic        hw_opt_reg,     hw_opt_next;
  logic        halt_opt_reg,   halt_opt_next;
  logic        long_opt_reg,   long_opt_next;
  logic        rst_act_reg,    rst_act_next;
  logic        rst_n_reg,      rst_n_next;
  logic        pready_reg,     pready_next;
  logic        pslverr_reg,    pslverr_next;
  logic [31:0] prdata_reg,     prdata_next;

  logic               tick;
  logic               dly_busy;
  logic               dly_done;
  logic               pulse_busy;
  logic               dly_start;
  logic               pulse_start;
  logic               wr_ctrl;
  logic               wr_cfg;
  logic               access;
  logic               eff_act;
  logic               counting;
  logic               dec;
  logic               trig_under;
  logic               trig_soft;
  logic               trig_halt;
  logic               trigger;
  logic               wr_act;
  logic [PRE_W-1:0]   min_lead;
  logic [TIMER_W-1:0] dly_load;

  // ==========================================================
  // apb decode: zero wait states, answer on first access edge
  assign access  = psel_in & penable_in & pready_reg;
  assign wr_ctrl = access & pwrite_in & (paddr_in == ADDR_CTRL);
  assign wr_cfg  = access & pwrite_in & (paddr_in == ADDR_CFG);

  always_comb begin
    pready_next  = psel_in & ~penable_in;
    pslverr_next = 1'b0;
    prdata_next  = prdata_reg;
    if (psel_in && !penable_in) begin
      prdata_next = '0;
      unique case (paddr_in)
        ADDR_CTRL: prdata_next[7:0] = {act_reg, cnt_reg};
        ADDR_CFG:  prdata_next[2:0] = {tb_reg, rtcie_reg};
        ADDR_STAT: begin
          prdata_next[STAT_RESET_BIT]  = rst_act_reg;
          prdata_next[STAT_FROZEN_BIT] = ~counting;
          prdata_next[STAT_ACTIVE_BIT] = eff_act;
          prdata_next[STAT_WAIT_BIT]   = dly_busy;
        end
        default:   pslverr_next = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // counter and activation
  // hardware option
  assign eff_act  = act_reg | hw_opt_reg;
  assign counting = (state_reg == WDW_RUN) | (state_reg == WDW_HALT_ONE);
  assign dec      = tick & counting & ~wr_ctrl;
  assign wr_act   = pwdata_in[CTRL_ACT_BIT] | eff_act;
  assign trig_under = dec & eff_act & (cnt_reg == CNT_EDGE_VALUE);
  assign trig_soft  = wr_ctrl & wr_act & ~pwdata_in[CTRL_TOP_BIT];
  assign trig_halt  = halt_in & (state_reg == WDW_RUN) & eff_act & ~rtcie_reg & halt_opt_reg;
  assign trigger    = (trig_under | trig_soft | trig_halt) & ~rst_act_reg;
  // shortest lead, clipped when the period is shortened
  assign min_lead   = (32'(tb_min_lead(tb_reg)) < PRESCALE) ? tb_min_lead(tb_reg) : PRE_W'(PRESCALE);

  always_comb begin
    cnt_next      = cnt_reg;
    act_next      = act_reg;
    rtcie_next    = rtcie_reg;
    tb_next       = tb_reg;
    hw_opt_next   = hw_opt_reg;
    halt_opt_next = halt_opt_reg;
    long_opt_next = long_opt_reg;
    rst_act_next  = rst_act_reg | trigger;
    // straps caught on the first cycle after release
    if (state_reg == WDW_BOOT) begin
      hw_opt_next   = hw_wdg_opt_in;
      halt_opt_next = halt_reset_opt_in;
      long_opt_next = long_delay_opt_in;
    end
    if (wr_ctrl) begin
      cnt_next = pwdata_in[6:0];
      act_next = act_reg | pwdata_in[CTRL_ACT_BIT];
    end else if (dec) begin
      cnt_next = cnt_reg - 7'h01;
    end
    if (wr_cfg) begin
      rtcie_next = pwdata_in[CFG_RTCIE_BIT];
      tb_next    = pwdata_in[CFG_TB_LSB +: 2];
    end
    // pin held low while the pulse runs; released when the pulse timer ends
    rst_n_next = ~(trigger | pulse_busy);
  end

  // ==========================================================
  // power-mode sequencer
  always_comb begin
    state_next  = state_reg;
    dly_start   = 1'b0;
    pulse_start = trigger;
    unique case (state_reg)
      // reset exit: disabled, counting after delay
      WDW_BOOT: begin
        dly_start  = 1'b1;
        state_next = WDW_WAIT;
      end
      WDW_WAIT: begin
        if (dly_done) begin
          state_next = WDW_RUN;
        end
      end
      WDW_RUN: begin
        if (halt_in && !trig_halt) begin
          state_next = rtcie_reg ? WDW_ACT_HALT : WDW_HALT_ONE;
        end
      end
      WDW_HALT_ONE: begin
        if (ext_irq_in) begin
          dly_start  = 1'b1;
          state_next = WDW_WAIT;
        end else if (dec) begin
          state_next = WDW_HALT_STOP;
        end
      end
      WDW_HALT_STOP: begin
        if (ext_irq_in) begin
          dly_start  = 1'b1;
          state_next = WDW_WAIT;
        end
      end
      WDW_ACT_HALT: begin
        if (ext_irq_in || osc_irq_in) begin
          state_next = WDW_RUN;
        end
      end
      default: state_next = WDW_BOOT;
    endcase
  end

  assign dly_load = long_opt_next ? TIMER_W'(RESUME_LONG_CYC) : TIMER_W'(RESUME_SHORT_CYC);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg    <= WDW_BOOT;
      cnt_reg      <= CTRL_CNT_RESET;
      act_reg      <= 1'b0;
      rtcie_reg    <= 1'b0;
      tb_reg       <= 2'h0;
      hw_opt_reg   <= 1'b0;
      halt_opt_reg <= 1'b0;
      long_opt_reg <= 1'b0;
      rst_act_reg  <= 1'b0;
      rst_n_reg    <= 1'b1;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      act_reg      <= act_next;
      rtcie_reg    <= rtcie_next;
      tb_reg       <= tb_next;
      hw_opt_reg   <= hw_opt_next;
      halt_opt_reg <= halt_opt_next;
      long_opt_reg <= long_opt_next;
      rst_act_reg  <= rst_act_next;
      rst_n_reg    <= rst_n_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      prdata_reg   <= prdata_next;
    end
  end

  // ==========================================================
  // submodules
  wdw_prescaler #(.PERIOD(PRESCALE)) u_pre (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .align_in    (wr_ctrl),
    .min_lead_in (min_lead),
    .tick_out    (tick)
  );

  wdw_timer #(.W(TIMER_W)) u_resume (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (dly_start),
    .load_in  (dly_load),
    .busy_out (dly_busy),
    .done_out (dly_done)
  );

  wdw_timer #(.W(TIMER_W)) u_pulse (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (pulse_start),
    .load_in  (TIMER_W'(RESET_PULSE_CYC)),
    .busy_out (pulse_busy),
    .done_out ()
  );

  // reset is the only chip-facing output
  assign reset_req_out    = rst_act_reg;
  assign chip_reset_n_out = rst_n_reg;
  assign prdata_out       = prdata_reg;
  assign pready_out       = pready_reg;
  assign pslverr_out      = pslverr_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_dec_step: assert property (dec |=> cnt_reg == $past(cnt_reg) - 7'h01)
    else $error("counter did not step down on tick");
  a_write_loads: assert property (wr_ctrl |=> cnt_reg == $past(pwdata_in[6:0]))
    else $error("write did not load counter");
  a_act_sticky: assert property (act_reg |=> act_reg)
    else $error("activation bit cleared");
  a_under_reset: assert property (dec && eff_act && cnt_reg == 7'h40 |=> rst_act_reg && cnt_reg == 7'h3f)
    else $error("underflow did not reset");
  a_pulse_low: assert property ($rose(rst_act_reg) |-> (!chip_reset_n_out)[*8])
    else $error("reset pin not held low");
  a_soft_reset: assert property (wr_ctrl && pwdata_in[7] && !pwdata_in[6] |=> rst_act_reg)
    else $error("software reset missing");
  a_no_reset_off: assert property (!eff_act && !wr_ctrl && !rst_act_reg |=> !rst_act_reg)
    else $error("reset while disabled");
  a_halt_reset: assert property (trig_halt |=> rst_act_reg && state_reg == WDW_RUN)
    else $error("halt reset missing");
  a_freeze_active: assert property (state_reg == WDW_ACT_HALT && $past(state_reg == WDW_ACT_HALT)
                                    |-> $stable(cnt_reg))
    else $error("counter moved in active-halt");
  a_halt_stopped: assert property (state_reg == WDW_HALT_STOP |-> !dec && !trig_under)
    else $error("plain halt still counting");
  a_resume_delay: assert property (state_reg == WDW_HALT_STOP && ext_irq_in |=> (state_reg == WDW_WAIT)[*8])
    else $error("resumed without delay");
  a_act_wake: assert property (state_reg == WDW_ACT_HALT && osc_irq_in |=> state_reg == WDW_RUN)
    else $error("active-halt wake not immediate");
  a_hw_active: assert property (hw_opt_reg && dec && cnt_reg == CNT_EDGE_VALUE |=> rst_act_reg)
    else $error("hardware option not active");

  c_underflow: cover property (trig_under);
  c_soft:      cover property (trig_soft);
  c_act_wake:  cover property (state_reg == WDW_ACT_HALT ##1 state_reg == WDW_RUN);
  c_halt_stop: cover property (state_reg == WDW_HALT_STOP ##1 state_reg == WDW_WAIT);

endmodule // wdw_watchdog

// >>> verification/wdw_rst_model.sv
// model of the chip reset circuit that listens to the watchdog pin
`timescale 1ns/1ps
module wdw_rst_model (
  // clock
  input  wire logic clk_in,
  // watchdog reset pin, active low
  input  wire logic chip_reset_n_in,
  // system reset back to the block, and measured pin-low length
  output logic      sys_rst_out,
  output int        low_len_out
);
  int cnt;
  int hold;

  initial begin
    cnt = 0;
    hold = 0;
    low_len_out = 0;
    sys_rst_out = 1'b0;
  end

  // ==========================================================
  // pin measurement and system reset
  // pin alone resets chip
  always @(posedge clk_in) begin
    if (hold != 0) begin
      hold <= hold - 1;
    end
    if (chip_reset_n_in === 1'b0) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      // reset follows the pin release, as a power-on style reset would
      low_len_out <= cnt;
      cnt <= 0;
      hold <= 16;
    end
    sys_rst_out <= (hold > 1);
  end
endmodule // wdw_rst_model

// >>> verification/tb.sv
// self-checking testbench for the watchdog down-counter
`timescale 1ns/1ps
module tb;
  import wdw_pkg::*;
  // shortened prescaler keeps each timeout a few hundred cycles
  localparam int unsigned PS = 64;

  logic        clk_in = 1'b0;
  logic        tb_rst = 1'b1;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [11:0] paddr  = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        halt   = 1'b0;
  logic        eirq   = 1'b0;
  logic        oirq   = 1'b0;
  logic        hw     = 1'b0;
  logic        hro    = 1'b0;
  logic        lng    = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        reset_req_out;
  logic        chip_reset_n_out;
  logic        sys_rst;
  int          low_len;
  wire logic   rst_in = tb_rst | sys_rst;
  logic [31:0] rd;
  logic        er;
  int          cyc;
  int          wt;
  int          bad_count = 0;
  int          compares = 0;

  always #4 clk_in = ~clk_in;

  wdw_watchdog #(.PRESCALE(PS)) i_wdw_watchdog (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .halt_in(halt), .ext_irq_in(eirq), .osc_irq_in(oirq),
    .hw_wdg_opt_in(hw), .halt_reset_opt_in(hro), .long_delay_opt_in(lng),
    .reset_req_out(reset_req_out), .chip_reset_n_out(chip_reset_n_out));

  wdw_rst_model i_wdw_rst_model (
    .clk_in(clk_in), .chip_reset_n_in(chip_reset_n_out), .sys_rst_out(sys_rst), .low_len_out(low_len));

  // ==========================================================
  // shared tasks
  task automatic final_report;
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic b);
    chk({31'h0, b}, 32'h1);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    // request stands until pready is seen at a rising edge
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) begin
      bad_count++;
    end
    wt = n;
    rd = prdata_out;
    er = pslverr_out;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wait_req(input int lim);
    cyc = 0;
    while (reset_req_out !== 1'b1 && cyc < lim) begin
      @(posedge clk_in);
      cyc++;
    end
  endtask

  task automatic recover;
    int n;
    n = 0;
    while (sys_rst !== 1'b1 && n < 5000) begin
      @(posedge clk_in);
      n++;
    end
    while (sys_rst !== 1'b0 && n < 5100) begin
      @(posedge clk_in);
      n++;
    end
    if (sys_rst !== 1'b0 || n >= 5000) begin
      bad_count++;
    end
    // startup freeze must pass before counting resumes
    repeat (300) @(posedge clk_in);
  endtask

  task automatic do_reset;
    @(posedge clk_in);
    tb_rst <= 1'b1;
    repeat (16) @(posedge clk_in);
    tb_rst <= 1'b0;
    repeat (300) @(posedge clk_in);
  endtask

  task automatic pulse_halt;
    @(posedge clk_in);
    halt <= 1'b1;
    @(posedge clk_in);
    halt <= 1'b0;
  endtask

  // ==========================================================
  // scenarios
  task automatic s_defaults;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000007f);
    chk(wt, 32'h1);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({31'h0, rd[STAT_ACTIVE_BIT]}, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chkb(er);
  endtask

  task automatic s_free;
    apb(1'b1, ADDR_CTRL, 32'h00000041);
    repeat (5 * PS) @(posedge clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chkb(rd[6:0] < 7'h40);
    chk({31'h0, reset_req_out}, 32'h0);
  endtask

  task automatic s_sticky;
    apb(1'b1, ADDR_CTRL, 32'h000000c2);
    apb(1'b1, ADDR_CTRL, 32'h00000042);
    // three decrements from 42h reach 3Fh
    wait_req(400);
    chkb(cyc >= 2 * PS && cyc <= 3 * PS + 10);
    recover();
    chk(low_len, RESET_PULSE_CYC + 1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000007f);
  endtask

  task automatic s_swrst;
    apb(1'b1, ADDR_CTRL, 32'h000000bf);
    wait_req(10);
    chkb(cyc <= 3);
    recover();
  endtask

  task automatic s_acthalt;
    apb(1'b1, ADDR_CFG, 32'h00000007);
    apb(1'b1, ADDR_CTRL, 32'h000000ff);
    pulse_halt();
    repeat (3 * PS) @(posedge clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h000000ff);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({31'h0, rd[STAT_FROZEN_BIT]}, 32'h1);
    @(posedge clk_in);
    oirq <= 1'b1;
    @(posedge clk_in);
    oirq <= 1'b0;
    repeat (3 * PS) @(posedge clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chkb(rd[6:0] < 7'h7f);
    apb(1'b1, ADDR_CFG, 32'h0);
  endtask

  task automatic s_plainhalt;
    apb(1'b1, ADDR_CTRL, 32'h000000ff);
    pulse_halt();
    repeat (4 * PS) @(posedge clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h000000fe);
    chk({31'h0, reset_req_out}, 32'h0);
    @(posedge clk_in);
    eirq <= 1'b1;
    @(posedge clk_in);
    eirq <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({31'h0, rd[STAT_WAIT_BIT]}, 32'h1);
    repeat (180) @(posedge clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h000000fe);
    repeat (200) @(posedge clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chkb(rd[6:0] < 7'h7e);
  endtask

  task automatic s_haltrst;
    hro <= 1'b1;
    do_reset();
    apb(1'b1, ADDR_CTRL, 32'h000000ff);
    pulse_halt();
    wait_req(10);
    chkb(cyc <= 4);
    hro <= 1'b0;
    recover();
  endtask

  task automatic s_hw;
    hw <= 1'b1;
    do_reset();
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({31'h0, rd[STAT_ACTIVE_BIT]}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h00000041);
    // two decrements from 41h, a step shorter than from 42h
    wait_req(300);
    chkb(cyc >= PS && cyc <= 2 * PS + 10);
    hw <= 1'b0;
    recover();
  endtask

  task automatic s_long;
    lng <= 1'b1;
    do_reset();
    // long startup freeze still holds after 4000 cycles
    repeat (3700) @(posedge clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000007f);
    repeat (300) @(posedge clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chkb(rd[6:0] < 7'h7f);
    lng <= 1'b0;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_in);
    tb_rst <= 1'b0;
    repeat (300) @(posedge clk_in);
    s_defaults();
    s_free();
    s_sticky();
    s_swrst();
    s_acthalt();
    s_plainhalt();
    s_haltrst();
    s_hw();
    s_long();
    final_report();
  end

  initial begin
    repeat (40000) @(posedge clk_in);
    bad_count++;
    final_report();
  end
endmodule // tb
